/* upfp_host.sv */
/*
  Host-side controller for a byte-wide asynchronous USB FIFO port.
  Reads received bytes, writes bytes to send, sends a wakeup strobe while
  the link is suspended and drives the device's active-low reset.
  Assumes the board resolves each two-way pin from out/oe_n pairs.
*/
// Behaviour
// RULE1 - device drives the receive byte on the bus while read strobe is low
// RULE2 - each falling read strobe moves the device to its next receive byte
// RULE3 - each falling write strobe stores the bus byte in the transmit FIFO
// RULE4 - host never writes while the transmit-space flag is high
// RULE5 - with space flag low, host pulses write strobe high then low
// RULE6 - host never reads while the receive-available flag is high
// RULE7 - with data waiting, host pulses read strobe low then high
// RULE8 - during device reset both flags float high through weak pull-ups
// RULE9 - suspended with wakeup enabled, the receive flag pin turns input
// RULE10 - host pulsing the receive flag low in suspend asks for resume
// RULE11 - driving the active-low reset input low resets the device
// RULE12 - in suspend the data and strobe pins are weakly pulled
// RULE13 - power enable goes low when configured, high in suspend
// RULE14 - host synchronises both flags before acting on them
`timescale 1ns/1ps
module upfp_host
  import upfp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user transmit side
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_done,
  // user receive side
  output logic [BYTE_W-1:0] rx_data,
  output logic rx_valid,
  // user control and status
  input wire logic wake_req,
  input wire logic dev_reset_req,
  output logic link_suspended,
  output logic link_configured,
  // data bus pins
  input wire logic [BYTE_W-1:0] fifo_byte_bus_in,
  output logic [BYTE_W-1:0] fifo_byte_bus_out,
  output logic fifo_byte_bus_oe_n,
  // strobe pins
  output logic rd_strobe_n,
  output logic wr_strobe,
  // flag pins
  input wire logic tx_space_flag_n,
  input wire logic rx_avail_flag_n_in,
  output logic rx_avail_flag_n_out,
  output logic rx_avail_flag_n_oe_n,
  // power and reset pins
  input wire logic power_enable_n,
  output logic device_reset_n
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [BYTE_W+2:0] pins_raw;
  logic [BYTE_W+2:0] pins_sync;
  logic [BYTE_W-1:0] bus_sync;
  logic txe_sync_n;
  logic rxf_sync_n;
  logic power_enable_n_sync_n;

  // bus bits cross one by one; a read holds its strobe until all of them settle
  assign pins_raw = {power_enable_n, rx_avail_flag_n_in, tx_space_flag_n, fifo_byte_bus_in};

  // flags reset to the idle-high level they show while the device is reset
  upfp_sync2 #(
    .WIDTH(BYTE_W + 3),
    .INIT({3'h7, BYTE_RESET})
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .din(pins_raw),
    .dout(pins_sync)
  ); // RULE14

  assign bus_sync = pins_sync[BYTE_W-1:0];
  assign txe_sync_n = pins_sync[BYTE_W];
  assign rxf_sync_n = pins_sync[BYTE_W+1];
  assign power_enable_n_sync_n = pins_sync[BYTE_W+2];

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  upfp_state_t state;
  upfp_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic cnt_done;
  logic is_idle;
  logic suspended;
  logic go_rd;
  logic go_wr;
  logic go_wake;

  assign cnt_done = (cnt == CNT_ZERO);
  assign is_idle = (state == ST_IDLE);
  assign suspended = power_enable_n_sync_n; // RULE13
  // a high flag (also the pulled-up level during device reset) blocks access
  // reads win over writes so the receive side of the device never backs up
  assign go_rd = is_idle && !suspended && !rxf_sync_n; // RULE6 RULE8
  assign go_wr = is_idle && !suspended && !go_rd && tx_valid && !txe_sync_n; // RULE4 RULE8
  // wakeup only makes sense while suspended, when the flag pin is an input
  // the host cannot see whether the device has wakeup enabled; the user decides
  assign go_wake = is_idle && suspended && wake_req; // RULE9 RULE10

  // counters load one less than the cycle count and each timed state exits on zero; ST_WR_HOLD always lasts one cycle

  always_comb begin
    next_state = state;
    next_cnt = cnt_done ? CNT_ZERO : cnt - 3'h1;
    unique case (state)
      ST_IDLE: begin
        if (go_rd) begin
          next_state = ST_RD_LOW;
          next_cnt = RD_LOW_LOAD;
        end else if (go_wr) begin
          next_state = ST_WR_HIGH;
          next_cnt = WR_HIGH_LOAD;
        end else if (go_wake) begin
          next_state = ST_WAKE;
          next_cnt = WAKE_LOAD;
        end
      end
      ST_RD_LOW: begin
        if (cnt_done) begin
          next_state = ST_RD_REC;
          next_cnt = RD_REC_LOAD;
        end
      end
      ST_WR_HIGH: begin
        if (cnt_done) begin
          next_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // data still driven one cycle past the falling write edge covers hold
        next_state = ST_WR_REC;
        next_cnt = WR_REC_LOAD;
      end
      ST_RD_REC, ST_WR_REC, ST_WAKE: begin
        if (cnt_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = CNT_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next pin and user values
  // ----------------------------------------------------------------
  logic next_rd_strobe_n;
  logic next_wr_strobe;
  logic next_bus_oe_n;
  logic [BYTE_W-1:0] next_bus_out;
  logic next_rxf_oe_n;
  logic next_rx_valid;
  logic next_tx_done;
  logic rd_sample;

  // strobe held low long enough for data valid plus the two sync stages
  assign next_rd_strobe_n = (next_state != ST_RD_LOW); // RULE7 RULE1 RULE2
  // strobe high with data set up, then a falling edge with data still held
  assign next_wr_strobe = (next_state == ST_WR_HIGH); // RULE5 RULE3
  assign next_bus_oe_n = !((next_state == ST_WR_HIGH) || (next_state == ST_WR_HOLD));
  assign next_bus_out = go_wr ? tx_data : fifo_byte_bus_out;
  // the pin is driven low only for the wakeup pulse, never outside suspend
  assign next_rxf_oe_n = (next_state != ST_WAKE); // RULE10
  // last cycle of the low phase: the bus byte has crossed both sync stages
  assign rd_sample = (state == ST_RD_LOW) && cnt_done; // RULE1
  assign next_rx_valid = rd_sample;
  // done marks the cycle after the hold cycle, once the byte is taken
  assign next_tx_done = (state == ST_WR_HOLD);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
      rd_strobe_n <= 1'b1;
      wr_strobe <= 1'b0;
      fifo_byte_bus_oe_n <= 1'b1;
      fifo_byte_bus_out <= BYTE_RESET;
      rx_avail_flag_n_out <= 1'b0;
      rx_avail_flag_n_oe_n <= 1'b1;
      rx_data <= BYTE_RESET;
      rx_valid <= 1'b0;
      tx_done <= 1'b0;
      link_suspended <= 1'b0;
      link_configured <= 1'b0;
      device_reset_n <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rd_strobe_n <= next_rd_strobe_n;
      wr_strobe <= next_wr_strobe;
      fifo_byte_bus_oe_n <= next_bus_oe_n;
      fifo_byte_bus_out <= next_bus_out;
      // only the enable moves, so the flag pin is never driven high
      rx_avail_flag_n_out <= 1'b0;
      rx_avail_flag_n_oe_n <= next_rxf_oe_n;
      rx_data <= rd_sample ? bus_sync : rx_data;
      rx_valid <= next_rx_valid;
      tx_done <= next_tx_done;
      link_suspended <= power_enable_n_sync_n; // RULE13
      link_configured <= !power_enable_n_sync_n;
      // a plain registered follow: no minimum width here, the user must hold it
      device_reset_n <= !dev_reset_req; // RULE11
    end
  end

endmodule

/* upfp_pkg.sv */
/*
  Constants for the host-side controller of a byte-wide asynchronous
  FIFO port: state codes, pin timings and cycle counts.
  Assumes a 40 MHz system clock; every count below is derived from it.
*/
package upfp_pkg;

  // ----------------------------------------------------------------
  // clock and synchroniser
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // pin timings in ns
  // ----------------------------------------------------------------
  localparam int RD_PULSE_NS = 50;
  localparam int RD_DATA_NS = 50;
  localparam int RD_PRECHARGE_NS = 130;
  localparam int WR_PULSE_NS = 50;
  localparam int WR_SETUP_NS = 20;
  localparam int WR_RECOVER_NS = 130;
  localparam int WAKE_PULSE_NS = 50;

  // ----------------------------------------------------------------
  // cycle counts, least times rounded up
  // ----------------------------------------------------------------
  // least whole clock cycles that cover a time in ns
  function automatic int ns_to_cyc(int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int cyc_max(int a, int b);
    return (a > b) ? a : b;
  endfunction

  localparam int RD_PULSE_CYC = ns_to_cyc(RD_PULSE_NS);
  localparam int RD_DATA_CYC = ns_to_cyc(RD_DATA_NS);
  localparam int RD_LOW_CYC = cyc_max(RD_PULSE_CYC, RD_DATA_CYC) + SYNC_STAGES;
  localparam int RD_REC_CYC = ns_to_cyc(RD_PRECHARGE_NS);
  localparam int WR_PULSE_CYC = ns_to_cyc(WR_PULSE_NS);
  localparam int WR_SETUP_CYC = ns_to_cyc(WR_SETUP_NS);
  localparam int WR_HIGH_CYC = cyc_max(WR_PULSE_CYC, WR_SETUP_CYC);
  localparam int WR_REC_CYC = ns_to_cyc(WR_RECOVER_NS);
  localparam int WAKE_CYC = ns_to_cyc(WAKE_PULSE_NS);

  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] RD_LOW_LOAD = CNT_W'(RD_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] RD_REC_LOAD = CNT_W'(RD_REC_CYC - 1);
  localparam logic [CNT_W-1:0] WR_HIGH_LOAD = CNT_W'(WR_HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] WR_REC_LOAD = CNT_W'(WR_REC_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_LOW = 3'b001,
    ST_RD_REC = 3'b010,
    ST_WR_HIGH = 3'b011,
    ST_WR_HOLD = 3'b100,
    ST_WR_REC = 3'b101,
    ST_WAKE = 3'b110
  } upfp_state_t;

endpackage

/* upfp_sync2.sv */
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a level that stays put long enough to be seen;
  bits of a word are not guaranteed to land on the same edge.
*/
`timescale 1ns/1ps
module upfp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level in and out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

/* upfp_host_chk.sv */
/* assertions on the host controller pins of the byte fifo port
   sees host ports only; bound to every upfp_host below */
`timescale 1ns/1ps
module upfp_host_chk (
  // clock, reset and controls
  input wire logic clk,
  input wire logic reset,
  input wire logic dev_reset_req,
  input wire logic rx_valid,
  input wire logic tx_done,
  input wire logic link_suspended,
  // pins
  input wire logic rd_strobe_n,
  input wire logic wr_strobe,
  input wire logic fifo_byte_bus_oe_n,
  input wire logic tx_space_flag_n,
  input wire logic rx_avail_flag_n_in,
  input wire logic rx_avail_flag_n_oe_n,
  input wire logic device_reset_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rd_low_width: assert property ($fell(rd_strobe_n) |=> !rd_strobe_n [*3] ##1 rd_strobe_n)
    else $error("read strobe width wrong");
  a_rd_data_due: assert property ($fell(rd_strobe_n) |-> ##4 rx_valid)
    else $error("read data late");
  a_wr_pulse_shape: assert property ($rose(wr_strobe) |=> wr_strobe ##1 !wr_strobe ##1 tx_done)
    else $error("write strobe shape wrong");
  a_wr_bus_held: assert property (wr_strobe || $fell(wr_strobe) |-> !fifo_byte_bus_oe_n)
    else $error("bus released during write");
  a_wr_needs_space: assert property ($rose(wr_strobe) |-> !$past(tx_space_flag_n, 3))
    else $error("write without space");
  a_rd_needs_data: assert property ($fell(rd_strobe_n) |-> !$past(rx_avail_flag_n_in, 3))
    else $error("read without data");
  a_rd_no_clash: assert property (!rd_strobe_n |-> fifo_byte_bus_oe_n && !wr_strobe)
    else $error("bus driven during read");
  a_wake_width: assert property ($fell(rx_avail_flag_n_oe_n) |=> !rx_avail_flag_n_oe_n ##1 rx_avail_flag_n_oe_n)
    else $error("wake pulse width wrong");
  a_wake_suspended: assert property (!rx_avail_flag_n_oe_n |-> link_suspended)
    else $error("wake outside suspend");
  a_dev_reset_follow: assert property (!$past(reset) |-> device_reset_n == !$past(dev_reset_req))
    else $error("device reset lags");
  c_read: cover property ($fell(rd_strobe_n));
  c_write: cover property ($rose(wr_strobe));
  c_wake: cover property ($fell(rx_avail_flag_n_oe_n));
endmodule
bind upfp_host upfp_host_chk u_chk (.*);

/* upfp_dev_model.sv */
/* behavioural model of the usb fifo device behind the host pins
   assumes the bench fills rxq and reads txq and wakes by hierarchy */
`timescale 1ns/1ps
module upfp_dev_model #(
  parameter bit PULL_LOW = 1'b0,
  parameter bit WAKE_EN = 1'b1
) (
  // host pins
  input wire logic rd_n,
  input wire logic wr,
  input wire logic [7:0] hbus,
  input wire logic hbus_oe_n,
  input wire logic hflag,
  input wire logic hflag_oe_n,
  input wire logic rst_n,
  // bench knobs
  input wire logic suspend,
  input wire logic hold_tx,
  // device pins
  output logic [7:0] bus,
  output logic txe_n,
  output logic rxf_n,
  output logic pe_n
);
  logic [7:0] rxq[$], txq[$];
  logic [7:0] cur = 8'h00, last = 8'h00;
  bit rx_busy, tx_busy;
  int wakes = 0;
  assign pe_n = suspend;
  // polled so that queue pushes from the bench need no sensitivity list
  always #1 begin
    if (!hbus_oe_n) bus = hbus;
    else if (!rd_n && rst_n) bus = cur;
    else if (suspend) bus = {8{!PULL_LOW}};
    else bus = ~last;
    if (!hbus_oe_n || !rd_n) last = bus;
    txe_n = !rst_n || tx_busy || hold_tx;
    // one assignment only: a glitch here would count as a wakeup
    rxf_n = (rst_n && suspend && WAKE_EN) ? (hflag_oe_n | hflag)
      : (!rst_n || rx_busy || rxq.size() == 0);
  end
  always @(negedge rd_n) if (rst_n && rxq.size() > 0) begin
    cur = rxq.pop_front();
    rx_busy = 1;
  end
  always @(posedge rd_n) #80 rx_busy = 0;
  always @(negedge wr) if (rst_n) begin
    txq.push_back(bus);
    tx_busy = 1;
    #80 tx_busy = 0;
  end
  always @(negedge rxf_n) if (rst_n && suspend && WAKE_EN) wakes++;
  always @(negedge rst_n) begin
    rxq.delete();
    txq.delete();
  end
endmodule

/* test_usb_parallel_fifo_port.sv */
/* self-checking bench for the host controller of the byte fifo port
   assumes the device model answers on every pin of the host */
`timescale 1ns/1ps
module test_usb_parallel_fifo_port;
  import upfp_pkg::*;
  logic clk = 0, reset = 1, tx_valid = 0, wake_req = 0, dev_reset_req = 0;
  logic suspend = 0, hold_tx = 0, tx_done, rx_valid, link_suspended, link_configured;
  logic [BYTE_W-1:0] tx_data = 8'h00, rx_data, fifo_byte_bus_in, fifo_byte_bus_out;
  logic fifo_byte_bus_oe_n, rd_strobe_n, wr_strobe, tx_space_flag_n, power_enable_n;
  logic rx_avail_flag_n_in, rx_avail_flag_n_out, rx_avail_flag_n_oe_n, device_reset_n;
  logic [7:0] rexp[$], texp[$];
  logic [31:0] seed = 32'h0000_02F4, r;
  int err_count = 0, compares = 0, cycles = 0;
  always #12.5 clk = ~clk;
  upfp_host dut (.*);
  upfp_dev_model m (.rd_n(rd_strobe_n), .wr(wr_strobe), .hbus(fifo_byte_bus_out),
    .hbus_oe_n(fifo_byte_bus_oe_n), .hflag(rx_avail_flag_n_out),
    .hflag_oe_n(rx_avail_flag_n_oe_n), .rst_n(device_reset_n), .suspend(suspend),
    .hold_tx(hold_tx), .bus(fifo_byte_bus_in), .txe_n(tx_space_flag_n),
    .rxf_n(rx_avail_flag_n_in), .pe_n(power_enable_n));
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic wait_rx();
    int n = 0;
    do begin
      tick(1);
      n++;
    end while (rx_valid !== 1'b1 && n < 40);
    chk("rx_valid", 1, rx_valid);
    chk("rx_data", rexp.pop_front(), rx_data);
  endtask
  // a stalled write raises the flag early, since the host sees it two flops late
  task automatic send(logic [7:0] b, int stall);
    int n = 0;
    hold_tx = stall > 0;
    tick(3);
    tx_data = b;
    tx_valid = 1;
    texp.push_back(b);
    do begin
      tick(1);
      n++;
      if (n < stall) chk("tx_refused", 0, tx_done);
      if (n == stall) hold_tx = 0;
    end while (tx_done !== 1'b1 && n < stall + 40);
    tx_valid = 0;
    chk("tx_done", 1, tx_done);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    tick(12);
    reset = 0;
    dev_reset_req = 1;
    tick(3);
    chk("device_reset_n", 0, device_reset_n);
    dev_reset_req = 0;
    tick(6);
    chk("link_configured", 1, link_configured);
    chk("device_reset_n", 1, device_reset_n);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      if (r[8]) begin
        for (int k = 0; k <= r[9]; k++) begin
          m.rxq.push_back(r[8*k+:8]);
          rexp.push_back(r[8*k+:8]);
        end
        while (rexp.size() > 0) wait_rx();
      end else send(r[7:0], r[9] ? 5 : 0);
    end
    while (texp.size() > 0) chk("tx_byte", texp.pop_front(), m.txq.pop_front());
    // a device reset mid-run floats both flags, so a waiting byte is held back
    dev_reset_req = 1;
    tick(2);
    m.rxq.push_back(8'h3C);
    rexp.push_back(8'h3C);
    tick(6);
    chk("device_reset_n", 0, device_reset_n);
    chk("flags_in_reset", 2'b11, {tx_space_flag_n, rx_avail_flag_n_in});
    chk("rd_held_off", 1, rd_strobe_n);
    dev_reset_req = 0;
    wait_rx();
    suspend = 1;
    m.rxq.push_back(8'hA5);
    tick(8);
    chk("link_state", 2'b10, {link_suspended, link_configured});
    r = m.wakes;
    wake_req = 1;
    tick(1);
    wake_req = 0;
    tick(8);
    chk("wakeups", r + 1, m.wakes);
    chk("rx_left", 1, m.rxq.size());
    give_verdict();
  end
endmodule
